// ### src/ecc_log_pkg.sv
package ecc_log_pkg;

    // Register field positions
    localparam int unsigned ECC_DISABLE_POS = 1;
    localparam int unsigned DIAG_MODE_POS = 2;
    localparam int unsigned PROTECT_PTR_POS = 3;
    localparam int unsigned SINGLE_FLAG_POS = 4;
    localparam int unsigned MULTI_LSB_POS = 5;
    localparam int unsigned PROTECT_EN_POS = 13;
    localparam int unsigned ADDR_HALF_POS = 14;
    localparam int unsigned UNCORR_FLAG_POS = 15;

    // Widths
    localparam int unsigned REG_WIDTH = 16;
    localparam int unsigned CHECK_WIDTH = 6;
    localparam int unsigned ADDR_MSB = 21;
    localparam int unsigned LOW_ADDR_WIDTH = 7;
    localparam int unsigned HIGH_ADDR_WIDTH = 4;

    // Protected segment: 16K words, so word address bit A15 picks the segment
    localparam int unsigned SEGMENT_SEL_POS = 15;

    // Values after reset
    localparam logic [CHECK_WIDTH-1:0] CHECK_RESET = 6'h00;
    localparam logic [ADDR_MSB:11] FAIL_ADDR_RESET = 11'h000;
    localparam logic [CHECK_WIDTH-1:0] SYNDROME_RESET = 6'h00;

    // The seven operating modes
    typedef enum logic [2:0] {
        MODE_NORMAL_ECC_ON = 3'b000,
        MODE_NORMAL_ECC_OFF = 3'b001,
        MODE_NORMAL_ECC_OFF_PROT = 3'b010,
        MODE_DIAG_ECC_ON = 3'b011,
        MODE_DIAG_ECC_OFF = 3'b100,
        MODE_DIAG_ECC_ON_PROT = 3'b101,
        MODE_DIAG_ECC_OFF_PROT = 3'b110
    } op_mode_t;

    // Control bits cleared by reset and by bus initialize
    typedef struct packed {
        logic uncorrectable_flag;
        logic addr_half_select;
        logic protect_enable_bit;
        logic single_flag;
        logic protect_region_pointer;
        logic diag_mode_bit;
        logic ecc_disable_bit;
    } ctrl_t;

    // One memory cycle as seen by the logging logic
    typedef struct packed {
        logic bus_read_cycle;
        logic bus_write_cycle;
        logic byte_write;
        logic [ADDR_MSB:1] addr;
        logic [CHECK_WIDTH-1:0] stored_check;
        logic [CHECK_WIDTH-1:0] syndrome;
        logic err_single;
        logic err_double;
    } mem_cycle_t;

    localparam ctrl_t CTRL_RESET = '0;

endpackage

// ### src/protect_region_check.sv
`timescale 1ns/1ps
module protect_region_check
    import ecc_log_pkg::*;
(
    input wire logic [ADDR_MSB:1] i_addr,
    input wire logic i_protect_enable_bit,
    input wire logic i_protect_region_pointer,
    input wire logic i_diag_mode_bit,
    input wire logic i_ecc_disable_bit,
    output logic o_in_protected,
    output logic o_diag_eff,
    output logic o_ecc_disable_eff
);
    logic in_window;

    // Only the two 16K-word segments can be protected
    assign in_window = (i_addr[ADDR_MSB:SEGMENT_SEL_POS+1] == '0);
    assign o_in_protected = i_protect_enable_bit && in_window &&
                            (i_addr[SEGMENT_SEL_POS] == i_protect_region_pointer); // [RULE5] [RULE12]

    // Clear enable leaves every word open to both modes
    assign o_diag_eff = i_diag_mode_bit && !o_in_protected; // [RULE4] [RULE5]
    assign o_ecc_disable_eff = i_ecc_disable_bit && !o_in_protected; // [RULE4] [RULE5]

endmodule

// ### src/ecc_error_log_control.sv
`timescale 1ns/1ps
// Summary of operation
// (RULE1) Diagnostic reads copy stored check bits into register bits 5-10.
// (RULE2) Diagnostic writes store register bits 5-10 as the word's check bits.
// (RULE3) Diagnostic with half select clear shows captured or injected check bits.
// (RULE4) Protect enable clear lets diagnostic and ECC-disable act on all memory.
// (RULE5) Protect enable set keeps one 16K-word segment out of both modes.
// (RULE6) Normal mode, half select clear: read shows failed A11-A17 on bits 5-11.
// (RULE7) Normal mode, half select set: read shows failed A18-A21 then A01 on bits 5-9.
// (RULE8) Half select set blocks software loads of the check-bit field.
// (RULE9) Uncorrectable flag sets on read double errors, or any single error with ECC disabled.
// (RULE10) Seven operating modes decoded from bits 1, 2 and 13.
// (RULE11) Bit 2 selects normal or diagnostic operation.
// (RULE12) Pointer bit 3 picks the first or second 16K words for protection.
// (RULE13) ECC-disable stops correction, keeps generation, all errors uncorrectable.
module ecc_error_log_control
    import ecc_log_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_bus_init,
    input wire logic i_reg_wr,
    input wire logic [REG_WIDTH-1:0] i_reg_wdata,
    input wire mem_cycle_t i_mem,
    input wire logic [CHECK_WIDTH-1:0] i_gen_check,
    output logic [REG_WIDTH-1:0] o_reg_rdata,
    output logic o_inject_check,
    output logic [CHECK_WIDTH-1:0] o_check_inject,
    output logic o_correct_en,
    output logic o_uncorrectable,
    output logic o_preserve_old,
    output logic o_error_led,
    output op_mode_t o_mode
);
    ctrl_t ctrl;
    ctrl_t next_ctrl;
    logic [CHECK_WIDTH-1:0] check_reg;
    logic [CHECK_WIDTH-1:0] next_check_reg;
    logic [ADDR_MSB:11] fail_addr_hi;
    logic [ADDR_MSB:11] next_fail_addr_hi;
    logic fail_a01;
    logic next_fail_a01;
    logic [CHECK_WIDTH-1:0] syndrome_reg;
    logic [CHECK_WIDTH-1:0] next_syndrome_reg;
    logic [REG_WIDTH-1:0] next_reg_rdata;
    logic in_protected;
    logic diag_eff;
    logic ecc_dis_eff;
    logic read_cycle;
    logic byte_cycle;
    logic set_single;
    logic set_uncorr;
    logic log_addr;
    ctrl_t wr_ctrl;

    // Decode the seven modes; protection only named when it is enabled
    function automatic op_mode_t decode_mode(input ctrl_t c);
        op_mode_t m;
        m = MODE_NORMAL_ECC_ON;
        case ({c.diag_mode_bit, c.ecc_disable_bit, c.protect_enable_bit})
            3'b000: m = MODE_NORMAL_ECC_ON;
            3'b001: m = MODE_NORMAL_ECC_ON;
            3'b010: m = MODE_NORMAL_ECC_OFF;
            3'b011: m = MODE_NORMAL_ECC_OFF_PROT;
            3'b100: m = MODE_DIAG_ECC_ON;
            3'b101: m = MODE_DIAG_ECC_ON_PROT;
            3'b110: m = MODE_DIAG_ECC_OFF;
            3'b111: m = MODE_DIAG_ECC_OFF_PROT;
            default: m = MODE_NORMAL_ECC_ON;
        endcase
        return m;
    endfunction

    // Control fields as carried by a register write
    function automatic ctrl_t unpack_ctrl(input logic [REG_WIDTH-1:0] d);
        ctrl_t c;
        c.uncorrectable_flag = d[UNCORR_FLAG_POS];
        c.addr_half_select = d[ADDR_HALF_POS];
        c.protect_enable_bit = d[PROTECT_EN_POS];
        c.single_flag = d[SINGLE_FLAG_POS];
        c.protect_region_pointer = d[PROTECT_PTR_POS];
        c.diag_mode_bit = d[DIAG_MODE_POS];
        c.ecc_disable_bit = d[ECC_DISABLE_POS];
        return c;
    endfunction

    protect_region_check u_protect (
        .i_addr(i_mem.addr),
        .i_protect_enable_bit(ctrl.protect_enable_bit),
        .i_protect_region_pointer(ctrl.protect_region_pointer),
        .i_diag_mode_bit(ctrl.diag_mode_bit),
        .i_ecc_disable_bit(ctrl.ecc_disable_bit),
        .o_in_protected(in_protected),
        .o_diag_eff(diag_eff),
        .o_ecc_disable_eff(ecc_dis_eff)
    );

    // Error classification for the current memory cycle
    always_comb begin
        read_cycle = i_mem.bus_read_cycle;
        byte_cycle = i_mem.bus_write_cycle && i_mem.byte_write;
        set_single = 1'b0;
        set_uncorr = 1'b0;
        log_addr = 1'b0;
        if (read_cycle) begin
            if (i_mem.err_double) begin
                set_uncorr = 1'b1; // [RULE9]
                log_addr = 1'b1;
            end else if (i_mem.err_single) begin
                if (ecc_dis_eff) begin
                    // Correction off: a single error is fatal too
                    set_single = 1'b1;
                    set_uncorr = 1'b1; // [RULE9] [RULE13]
                    log_addr = 1'b1;
                end else if (!(ctrl.ecc_disable_bit && in_protected)) begin
                    set_single = 1'b1;
                    log_addr = !ctrl.uncorrectable_flag;
                end
            end
        end else if (byte_cycle && i_mem.err_single && !i_mem.err_double) begin
            // Read-modify-write: single errors log, doubles are preserved
            if (ecc_dis_eff) begin
                set_single = 1'b1;
                set_uncorr = 1'b1; // [RULE13]
                log_addr = 1'b1;
            end else if (!(ctrl.ecc_disable_bit && in_protected)) begin
                set_single = 1'b1;
                log_addr = !ctrl.uncorrectable_flag;
            end
        end
    end

    // Control register: bus initialize clears, hardware sets beat software clears
    always_comb begin
        wr_ctrl = unpack_ctrl(i_reg_wdata);
        next_ctrl = ctrl;
        if (i_bus_init) begin
            next_ctrl = CTRL_RESET;
        end else if (i_reg_wr) begin
            next_ctrl = wr_ctrl; // [RULE11] [RULE12]
        end
        if (set_single) begin
            next_ctrl.single_flag = 1'b1;
        end
        if (set_uncorr) begin
            next_ctrl.uncorrectable_flag = 1'b1; // [RULE9]
        end
    end

    // Check-bit field: software load, or capture on diagnostic reads
    always_comb begin
        next_check_reg = check_reg;
        if (i_reg_wr && !ctrl.addr_half_select) begin
            next_check_reg = i_reg_wdata[MULTI_LSB_POS +: CHECK_WIDTH]; // [RULE8]
        end
        if (read_cycle && diag_eff) begin
            next_check_reg = i_mem.stored_check; // [RULE1]
        end
    end

    // Failed address and syndrome latches
    always_comb begin
        next_fail_addr_hi = fail_addr_hi;
        next_fail_a01 = fail_a01;
        next_syndrome_reg = syndrome_reg;
        if (log_addr) begin
            next_fail_addr_hi = i_mem.addr[ADDR_MSB:11];
            next_fail_a01 = i_mem.addr[1];
            next_syndrome_reg = i_mem.syndrome;
        end
    end

    // Read-back multiplexer for bits 5 to 11
    always_comb begin
        next_reg_rdata = '0;
        next_reg_rdata[UNCORR_FLAG_POS] = ctrl.uncorrectable_flag;
        next_reg_rdata[ADDR_HALF_POS] = ctrl.addr_half_select;
        next_reg_rdata[PROTECT_EN_POS] = ctrl.protect_enable_bit;
        next_reg_rdata[SINGLE_FLAG_POS] = ctrl.single_flag;
        next_reg_rdata[PROTECT_PTR_POS] = ctrl.protect_region_pointer;
        next_reg_rdata[DIAG_MODE_POS] = ctrl.diag_mode_bit;
        next_reg_rdata[ECC_DISABLE_POS] = ctrl.ecc_disable_bit;
        case ({ctrl.diag_mode_bit, ctrl.addr_half_select})
            2'b00: begin
                next_reg_rdata[MULTI_LSB_POS +: LOW_ADDR_WIDTH] = fail_addr_hi[17:11]; // [RULE6]
            end
            2'b01: begin
                next_reg_rdata[MULTI_LSB_POS +: HIGH_ADDR_WIDTH] = fail_addr_hi[21:18]; // [RULE7]
                next_reg_rdata[MULTI_LSB_POS + HIGH_ADDR_WIDTH] = fail_a01; // [RULE7]
            end
            2'b10: begin
                next_reg_rdata[MULTI_LSB_POS +: CHECK_WIDTH] = check_reg; // [RULE3]
            end
            2'b11: begin
                next_reg_rdata[MULTI_LSB_POS +: CHECK_WIDTH] = syndrome_reg;
            end
            default: begin
                next_reg_rdata = '0;
            end
        endcase
    end

    // Control bits follow reset and bus initialize
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl <= CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // Logged fields survive bus initialize; reset only gives them a defined start
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            check_reg <= CHECK_RESET;
            fail_addr_hi <= FAIL_ADDR_RESET;
            fail_a01 <= 1'b0;
            syndrome_reg <= SYNDROME_RESET;
            o_reg_rdata <= '0;
        end else begin
            check_reg <= next_check_reg;
            fail_addr_hi <= next_fail_addr_hi;
            fail_a01 <= next_fail_a01;
            syndrome_reg <= next_syndrome_reg;
            o_reg_rdata <= next_reg_rdata;
        end
    end

    // Data path steering, same cycle as the memory access
    assign o_inject_check = i_mem.bus_write_cycle && diag_eff; // [RULE2]
    assign o_check_inject = check_reg; // [RULE2]
    assign o_correct_en = !ecc_dis_eff; // [RULE13]
    assign o_uncorrectable = read_cycle && (i_mem.err_double ||
                             (i_mem.err_single && ecc_dis_eff)); // [RULE9] [RULE13]
    assign o_preserve_old = byte_cycle && i_mem.err_double;
    assign o_error_led = ctrl.uncorrectable_flag;
    assign o_mode = decode_mode(ctrl); // [RULE10]

endmodule

// ### dv/ecc_log_properties.sv
`timescale 1ns/1ps
module ecc_log_properties
    import ecc_log_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_bus_init,
    input wire logic i_reg_wr,
    input wire logic [REG_WIDTH-1:0] i_reg_wdata,
    input wire mem_cycle_t i_mem,
    input wire logic [CHECK_WIDTH-1:0] i_gen_check,
    input wire logic [REG_WIDTH-1:0] o_reg_rdata,
    input wire logic o_inject_check,
    input wire logic [CHECK_WIDTH-1:0] o_check_inject,
    input wire logic o_correct_en,
    input wire logic o_uncorrectable,
    input wire logic o_preserve_old,
    input wire logic o_error_led,
    input wire op_mode_t o_mode
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic rd, wr, quiet, diag_open;
    // Read image lags one cycle, so results are checked after an idle cycle
    assign rd = i_mem.bus_read_cycle;
    assign wr = i_mem.bus_write_cycle;
    assign quiet = !i_reg_wr && !rd && !wr && !i_bus_init;
    assign diag_open = o_mode inside {MODE_DIAG_ECC_ON, MODE_DIAG_ECC_OFF};
    sequence diag_read_s;
        rd && diag_open && !i_reg_wr && !i_bus_init ##1 quiet;
    endsequence
    sequence double_read_s;
        rd && i_mem.err_double && o_mode == MODE_NORMAL_ECC_ON && !i_reg_wr ##1 quiet;
    endsequence
    diag_capture_a: assert property (
        diag_read_s |=> o_reg_rdata[14] || o_reg_rdata[10:5] == $past(i_mem.stored_check, 2))
        else $error("check bits not captured");
    diag_inject_a: assert property (wr && diag_open |-> o_inject_check)
        else $error("check bits not injected");
    protect_hold_a: assert property (
        wr && o_reg_rdata[13] && !$past(i_reg_wr) && i_mem.addr[21:16] == 6'h00
        && i_mem.addr[15] == o_reg_rdata[3] |-> !o_inject_check)
        else $error("protected segment injected");
    double_flag_a: assert property (rd && i_mem.err_double |-> o_uncorrectable)
        else $error("double error not flagged");
    single_off_a: assert property (
        rd && i_mem.err_single && !i_mem.err_double && o_mode == MODE_NORMAL_ECC_OFF
        |-> o_uncorrectable && !o_correct_en)
        else $error("single error with ecc off");
    single_on_a: assert property (
        rd && i_mem.err_single && !i_mem.err_double && o_mode == MODE_NORMAL_ECC_ON
        |-> !o_uncorrectable && o_correct_en)
        else $error("single error with ecc on");
    flag_led_a: assert property (double_read_s |-> o_error_led ##1 o_reg_rdata[15])
        else $error("flag not shown");
    low_addr_a: assert property (
        double_read_s |=> o_reg_rdata[14] || o_reg_rdata[11:5] == $past(i_mem.addr[17:11], 2))
        else $error("low address wrong");
    half_block_a: assert property (
        i_reg_wr && o_reg_rdata[14] && !$past(i_reg_wr) && !rd |=> $stable(o_check_inject))
        else $error("check field loaded");
    preserve_old_a: assert property (
        wr && i_mem.byte_write && i_mem.err_double |-> o_preserve_old && !o_uncorrectable)
        else $error("byte double not preserved");
    byte_quiet_a: assert property (
        wr && i_mem.byte_write && i_mem.err_double && !i_reg_wr && !i_bus_init
        |=> $stable(o_error_led))
        else $error("byte double flagged");
    mode_normal_a: assert property (
        i_reg_wr && i_reg_wdata[2:1] == 2'b00 && !i_bus_init |=> o_mode == MODE_NORMAL_ECC_ON)
        else $error("mode decode wrong");
endmodule

// ### dv/bus_host.sv
`timescale 1ns/1ps
module bus_host
    import ecc_log_pkg::*;
(
    input wire logic i_clk,
    output logic o_reg_wr,
    output logic [REG_WIDTH-1:0] o_reg_wdata,
    output mem_cycle_t o_mem,
    output logic [CHECK_WIDTH-1:0] o_gen_check
);
    // Idle bus at time zero
    initial begin
        o_reg_wr = 1'b0;
        o_reg_wdata = 16'h0000;
        o_mem = '0;
        o_gen_check = 6'h00;
    end
    // Strobe held across exactly one edge; released data is inverted, not left valid
    task reg_write(input logic [15:0] d);
        @(posedge i_clk);
        #1 o_reg_wr = 1'b1;
        o_reg_wdata = d;
        @(posedge i_clk);
        #1 o_reg_wr = 1'b0;
        o_reg_wdata = ~d;
    endtask
    // Opens a read or word write; caller looks at outputs, then calls idle
    task mem_op(input logic w, input logic [21:1] a, input logic [5:0] c, input logic [1:0] e);
        @(posedge i_clk);
        #1 o_mem = {~w, w, 1'b0, a, c, a[6:1], e};
        o_gen_check = ~c;
    endtask
    // Byte write: the word is read first, so its error bits matter here
    task byte_op(input logic [21:1] a, input logic [5:0] c, input logic [1:0] e);
        @(posedge i_clk);
        #1 o_mem = {3'b011, a, c, a[6:1], e};
        o_gen_check = ~c;
    endtask
    task idle();
        @(posedge i_clk);
        #1 o_mem = {3'b000, ~o_mem.addr, ~o_mem.stored_check, ~o_mem.syndrome, 2'b00};
    endtask
endmodule

// ### dv/ecc_error_log_control_bench.sv
`timescale 1ns/1ps
module ecc_error_log_control_bench;
    import ecc_log_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_bus_init = 1'b0;
    logic i_reg_wr, o_inject_check, o_correct_en, o_uncorrectable, o_preserve_old, o_error_led;
    logic [REG_WIDTH-1:0] i_reg_wdata, o_reg_rdata;
    logic [CHECK_WIDTH-1:0] i_gen_check, o_check_inject;
    mem_cycle_t i_mem;
    op_mode_t o_mode;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    int sel = 0;
    integer seed = 14;
    logic look = 1'b0;
    logic [15:0] seen;
    logic [15:0] exp_q[$];
    string name_q[$];
    logic [21:1] a;
    logic [5:0] c;
    op_mode_t mode_tab[8] = '{MODE_NORMAL_ECC_ON, MODE_NORMAL_ECC_OFF, MODE_DIAG_ECC_ON,
        MODE_DIAG_ECC_OFF, MODE_NORMAL_ECC_ON, MODE_NORMAL_ECC_OFF_PROT, MODE_DIAG_ECC_ON_PROT,
        MODE_DIAG_ECC_OFF_PROT};
    always #10 i_clk = ~i_clk;
    bus_host i_bus_host(.i_clk, .o_reg_wr(i_reg_wr), .o_reg_wdata(i_reg_wdata), .o_mem(i_mem),
        .o_gen_check(i_gen_check));
    ecc_error_log_control i_ecc_error_log_control(.i_clk, .i_reset, .i_bus_init, .i_reg_wr,
        .i_reg_wdata, .i_mem, .i_gen_check, .o_reg_rdata, .o_inject_check, .o_check_inject,
        .o_correct_en, .o_uncorrectable, .o_preserve_old, .o_error_led, .o_mode);
    // Output picked for the current note
    always_comb begin
        case (sel)
            0: seen = o_reg_rdata;
            1: seen = {9'h000, o_inject_check, o_check_inject};
            2: seen = {13'h0000, o_preserve_old, o_uncorrectable, o_correct_en};
            default: seen = {13'h0000, o_mode};
        endcase
    end
    task check(input string what, input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Watcher compares at the falling edge, mid-cycle, where outputs are settled
    always @(negedge i_clk) begin
        if (look) begin
            check(name_q.pop_front(), seen, exp_q.pop_front());
        end
    end
    task note(input string what, input int s, input logic [15:0] e);
        sel = s;
        exp_q.push_back(e);
        name_q.push_back(what);
        look = 1'b1;
        @(negedge i_clk);
        #1 look = 1'b0;
        $display("test %s done", what);
    endtask
    task settle();
        @(posedge i_clk);
        #1;
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk);
        #1 i_reset = 1'b0;
        note("reset mode", 3, {13'h0000, MODE_NORMAL_ECC_ON});
        a = 21'($random(seed));
        c = 6'($random(seed));
        i_bus_host.reg_write(16'h0004);
        i_bus_host.mem_op(1'b0, a, c, 2'b00);
        note("diag read", 2, 16'h0001);
        i_bus_host.idle();
        settle();
        note("capture", 0, {5'h00, c, 5'h04});
        i_bus_host.mem_op(1'b1, a, ~c, 2'b00);
        note("inject", 1, {9'h000, 1'b1, c});
        i_bus_host.idle();
        i_bus_host.reg_write({5'h08, c, 5'h04});
        i_bus_host.reg_write({5'h08, ~c, 5'h04});
        note("half block", 1, {9'h000, 1'b0, c});
        for (int p = 0; p < 2; p++) begin
            i_bus_host.reg_write({5'h04, c, 1'b0, p[0], 3'b100});
            for (int s = 0; s < 2; s++) begin
                i_bus_host.mem_op(1'b1, {6'h00, s[0], a[14:1]}, c, 2'b00);
                note("protect", 1, {9'h000, s[0] != p[0], c});
                i_bus_host.idle();
            end
        end
        i_bus_host.reg_write(16'h0000);
        i_bus_host.mem_op(1'b0, a, c, 2'b01);
        note("double", 2, 16'h0003);
        i_bus_host.idle();
        settle();
        note("low addr", 0, {1'b1, 3'h0, a[17:11], 5'h00});
        i_bus_host.reg_write(16'hc000);
        settle();
        note("high addr", 0, {6'h30, a[1], a[21:18], 5'h00});
        // Diagnostic with half select set shows the syndrome of the double error
        i_bus_host.reg_write(16'hc004);
        settle();
        note("syndrome", 0, {5'h18, a[6:1], 5'h04});
        for (int d = 0; d < 2; d++) begin
            i_bus_host.reg_write({14'h0000, d[0], 1'b0});
            i_bus_host.mem_op(1'b0, a, c, 2'b10);
            note("single", 2, {14'h0000, d[0], ~d[0]});
            i_bus_host.idle();
        end
        // Byte write over a double error keeps the old word, correction still off
        i_bus_host.byte_op(a, c, 2'b01);
        note("preserve", 2, 16'h0004);
        i_bus_host.idle();
        // Bus initialize clears control bits but keeps the logged address
        @(posedge i_clk);
        #1 i_bus_init = 1'b1;
        @(posedge i_clk);
        #1 i_bus_init = 1'b0;
        settle();
        note("bus init", 0, {4'h0, a[17:11], 5'h00});
        for (int i = 0; i < 8; i++) begin
            i_bus_host.reg_write({2'b00, i[2], 10'h000, i[1:0], 1'b0});
            note("mode", 3, {13'h0000, mode_tab[i]});
        end
        close_out();
    end
endmodule
bind ecc_error_log_control ecc_log_properties i_ecc_log_properties(.i_clk, .i_reset, .i_bus_init,
    .i_reg_wr, .i_reg_wdata, .i_mem, .i_gen_check, .o_reg_rdata, .o_inject_check, .o_check_inject,
    .o_correct_en, .o_uncorrectable, .o_preserve_old, .o_error_led, .o_mode);
